// >>> src/rev_pkg.sv
// Purpose: constants and carrier types for the counter event/irq-enable control block
// Assumes: register indices are word indices, byte address = index * 4
// Notes:   enable-layout bits shared by irq enables and irq flags
package rev_pkg;
  // register word indices
  localparam logic [5:0] IDX_CTRL   = 6'h00;
  localparam logic [5:0] IDX_EVENT_OUTPUT_CONTROL = 6'h04;
  localparam logic [5:0] IDX_IENCLR = 6'h06;
  localparam logic [5:0] IDX_IENSET = 6'h07;
  localparam logic [5:0] IDX_FLAG   = 6'h08;
  localparam logic [5:0] IDX_WPROT  = 6'h09;
  // control register fields
  localparam int CTRL_EN_BIT   = 1;
  localparam int CTRL_MODE_LSB = 2;
  // event control fields
  localparam int EV_OVF_BIT  = 15;
  localparam int EV_CH1_BIT  = 9;
  localparam int EV_CH0_BIT  = 8;
  localparam int EV_PER_NUM  = 8;
  localparam logic [15:0] EV_WMASK = 16'h83ff;
  localparam logic [15:0] EV_RESET = 16'h0000;
  // irq enable / flag fields
  localparam int IRQ_OVF_BIT  = 7;
  localparam int IRQ_SYNC_BIT = 6;
  localparam int IRQ_CH1_BIT  = 1;
  localparam int IRQ_CH0_BIT  = 0;
  localparam logic [7:0] IRQ_WMASK = 8'hc3;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  typedef enum logic [1:0] {
    REV_WIDE_COUNTER   = 2'h0,
    REV_NARROW_COUNTER = 2'h1,
    REV_CALENDAR       = 2'h2,
    REV_MODE_RSVD      = 2'h3
  } rev_mode_t;
  // condition strobes from the counter core, one cycle each
  typedef struct packed {
    logic       ovf;
    logic       sync_rdy;
    logic [1:0] cmp;
    logic       alarm0;
    logic [7:0] per;
  } rev_hit_t;
  // event strobes to the event routing system
  typedef struct packed {
    logic       ovf;
    logic [1:0] cmp;
    logic       alarm0;
    logic [7:0] per;
  } rev_evt_t;
endpackage

// >>> src/rev_ctrl.sv
// Purpose: event output enables and irq enable set/clear for a real-time counter
// Assumes: hit strobes are synchronous to pclk, one cycle wide
// Notes:   apb slave, zero wait states while cen is high
`timescale 1ns/100ps
module rev_ctrl (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              cen,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire rev_pkg::rev_hit_t hits,
  output rev_pkg::rev_evt_t      evts,
  output logic                   irq
);
  logic [1:0]  mode_r;
  logic [1:0]  mode_nxt;
  logic        enable_r;
  logic        enable_nxt;
  logic        wprot_r;
  logic        wprot_nxt;
  logic [15:0] event_output_control_r;
  logic [15:0] event_output_control_nxt;
  logic [7:0]  ien_r;
  logic [7:0]  ien_nxt;
  logic [7:0]  flag_r;
  logic [7:0]  flag_nxt;
  logic [7:0]  flag_set;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        cap_r;
  logic        cap_nxt;
  logic [31:0] rdata;
  logic        mapped;
  logic        wr;
  logic        ev_open;

  // bus decode
  always_comb
  begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == {rev_pkg::IDX_CTRL, 2'b00})
    begin
      rdata[rev_pkg::CTRL_MODE_LSB +: 2] = mode_r;
      rdata[rev_pkg::CTRL_EN_BIT]        = enable_r;
    end
    else if (paddr == {rev_pkg::IDX_EVENT_OUTPUT_CONTROL, 2'b00})
    begin
      rdata[15:0] = event_output_control_r;
    end
    else if (paddr == {rev_pkg::IDX_IENCLR, 2'b00})
    begin
      rdata[7:0] = ien_r;
    end
    else if (paddr == {rev_pkg::IDX_IENSET, 2'b00})
    begin
      rdata[7:0] = ien_r;
    end
    else if (paddr == {rev_pkg::IDX_FLAG, 2'b00})
    begin
      rdata[7:0] = flag_r;
    end
    else if (paddr == {rev_pkg::IDX_WPROT, 2'b00})
    begin
      rdata[0] = wprot_r;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  // read data is captured a cycle early so prdata comes from a flop
  assign pready  = cen & psel & penable & cap_r;
  assign pslverr = pready & ~mapped;
  assign prdata  = prdata_r;
  assign wr      = pready & pwrite & mapped;

  always_comb
  begin
    cap_nxt    = psel & ~(penable & pready);
    prdata_nxt = psel ? rdata : prdata_r;
  end

  // control and protection
  always_comb
  begin
    mode_nxt   = mode_r;
    enable_nxt = enable_r;
    wprot_nxt  = wprot_r;
    if (wr && paddr == {rev_pkg::IDX_CTRL, 2'b00} && !wprot_r)
    begin
      enable_nxt = pwdata[rev_pkg::CTRL_EN_BIT];
      // mode only changes while the peripheral is off
      if (!enable_r)
      begin
        mode_nxt = pwdata[rev_pkg::CTRL_MODE_LSB +: 2];
      end
    end
    if (wr && paddr == {rev_pkg::IDX_WPROT, 2'b00})
    begin
      wprot_nxt = pwdata[0];
    end
  end

  // event control register, one copy for every mode
  assign ev_open = !enable_r && !wprot_r;
  always_comb
  begin
    event_output_control_nxt = event_output_control_r;
    if (wr && paddr == {rev_pkg::IDX_EVENT_OUTPUT_CONTROL, 2'b00} && ev_open)
    begin
      event_output_control_nxt = pwdata[15:0] & rev_pkg::EV_WMASK;
    end
  end

  // irq enables: clear via enable-clear, set via enable-set
  always_comb
  begin
    ien_nxt = ien_r;
    if (wr && paddr == {rev_pkg::IDX_IENCLR, 2'b00} && !wprot_r)
    begin
      // zero bits leave enables alone
      ien_nxt = ien_r & ~(pwdata[7:0] & rev_pkg::IRQ_WMASK);
    end
    else if (wr && paddr == {rev_pkg::IDX_IENSET, 2'b00} && !wprot_r)
    begin
      ien_nxt = ien_r | (pwdata[7:0] & rev_pkg::IRQ_WMASK);
    end
  end

  // sticky flags, set wins over a same-cycle write-one clear
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[rev_pkg::IRQ_OVF_BIT]  = hits.ovf;
    flag_set[rev_pkg::IRQ_SYNC_BIT] = hits.sync_rdy;
    case (rev_pkg::rev_mode_t'(mode_r))
      rev_pkg::REV_WIDE_COUNTER:
        flag_set[rev_pkg::IRQ_CH0_BIT] = hits.cmp[0];
      rev_pkg::REV_NARROW_COUNTER:
      begin
        flag_set[rev_pkg::IRQ_CH0_BIT] = hits.cmp[0];
        flag_set[rev_pkg::IRQ_CH1_BIT] = hits.cmp[1];
      end
      rev_pkg::REV_CALENDAR:
        flag_set[rev_pkg::IRQ_CH0_BIT] = hits.alarm0;
      default:
        flag_set[rev_pkg::IRQ_CH0_BIT] = 1'b0;
    endcase
    flag_nxt = flag_r;
    if (wr && paddr == {rev_pkg::IDX_FLAG, 2'b00})
    begin
      flag_nxt = flag_r & ~pwdata[7:0];
    end
    flag_nxt = flag_nxt | flag_set;
  end

  assign irq = |(flag_r & ien_r);

  // event outputs, combinational so they land in the condition's own cycle
  genvar gi;
  generate
    for (gi = 0; gi < rev_pkg::EV_PER_NUM; gi++)
    begin : g_per
      assign evts.per[gi] = cen & hits.per[gi] & event_output_control_r[gi];
    end
  endgenerate
  assign evts.ovf    = cen & hits.ovf & event_output_control_r[rev_pkg::EV_OVF_BIT];
  assign evts.cmp[0] = cen & hits.cmp[0] & event_output_control_r[rev_pkg::EV_CH0_BIT]
                       & (mode_r == rev_pkg::REV_WIDE_COUNTER
                          || mode_r == rev_pkg::REV_NARROW_COUNTER);
  assign evts.cmp[1] = cen & hits.cmp[1] & event_output_control_r[rev_pkg::EV_CH1_BIT]
                       & (mode_r == rev_pkg::REV_NARROW_COUNTER);
  assign evts.alarm0 = cen & hits.alarm0 & event_output_control_r[rev_pkg::EV_CH0_BIT]
                       & (mode_r == rev_pkg::REV_CALENDAR);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r   <= 2'h0;
      enable_r <= 1'b0;
      wprot_r  <= 1'b0;
      event_output_control_r <= rev_pkg::EV_RESET;
      ien_r    <= rev_pkg::IRQ_RESET;
      flag_r   <= rev_pkg::IRQ_RESET;
      prdata_r <= 32'h0000_0000;
      cap_r    <= 1'b0;
    end
    else if (cen)
    begin
      mode_r   <= mode_nxt;
      enable_r <= enable_nxt;
      wprot_r  <= wprot_nxt;
      event_output_control_r <= event_output_control_nxt;
      ien_r    <= ien_nxt;
      flag_r   <= flag_nxt;
      prdata_r <= prdata_nxt;
      cap_r    <= cap_nxt;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic clr_wr;
  assign clr_wr = wr && paddr == {rev_pkg::IDX_IENCLR, 2'b00} && !wprot_r;

  a_per_tap_gate: assert property (
    (evts.per & ~event_output_control_r[7:0]) == 8'h00 && (!cen || evts.per == (hits.per & event_output_control_r[7:0])))
    else $error("periodic event escaped its enable");
  a_ovf_event_gate: assert property (
    cen && hits.ovf |-> evts.ovf == event_output_control_r[rev_pkg::EV_OVF_BIT])
    else $error("overflow event does not follow its enable");
  a_cmp_event_narrow: assert property (
    cen && mode_r == rev_pkg::REV_NARROW_COUNTER && hits.cmp[1] && event_output_control_r[9]
    |-> evts.cmp[1] && !evts.alarm0)
    else $error("compare 1 event missing in narrow mode");
  a_alarm_event_cal: assert property (
    cen && mode_r == rev_pkg::REV_CALENDAR && hits.alarm0 |-> evts.alarm0 == event_output_control_r[8]
    && evts.cmp == 2'b00)
    else $error("alarm event wrong in calendar mode");
  a_event_output_control_write: assert property (
    cen && wr && paddr == {rev_pkg::IDX_EVENT_OUTPUT_CONTROL, 2'b00} && ev_open
    |=> event_output_control_r == ($past(pwdata[15:0]) & rev_pkg::EV_WMASK))
    else $error("event control write not stored");
  a_event_output_control_locked: assert property (
    cen && (enable_r || wprot_r) |=> $stable(event_output_control_r))
    else $error("event control changed while protected");
  a_ovf_ien_clear: assert property (
    cen && clr_wr && pwdata[7] |=> !ien_r[7] ##1 (!ien_r[7] || $past(wr)))
    else $error("overflow irq enable not cleared");
  a_sync_ien_keep: assert property (
    cen && clr_wr && !pwdata[6] && ien_r[6] |=> ien_r[6])
    else $error("zero write disturbed sync-ready enable");
  a_compare0_irq_en_ien_clear: assert property (
    cen && clr_wr && pwdata[0] |=> !ien_r[0])
    else $error("compare 0 irq enable not cleared");
  a_irq_raise: assert property (
    cen && ien_r[7] && hits.ovf && !(clr_wr && pwdata[7]) |=> irq)
    else $error("irq not raised for enabled overflow");
  a_mode_rsvd: assert property (
    mode_r == rev_pkg::REV_MODE_RSVD |-> evts.cmp == 2'b00 && !evts.alarm0)
    else $error("compare or alarm event in reserved mode");
  a_event_pulse: assert property (
    !hits.ovf && hits.cmp == 2'b00 |-> !evts.ovf && evts.cmp == 2'b00)
    else $error("event without its condition");
  a_sync_ien_clear: assert property (
    cen && clr_wr && pwdata[rev_pkg::IRQ_SYNC_BIT] |=> !ien_r[rev_pkg::IRQ_SYNC_BIT])
    else $error("sync-ready irq enable not cleared");
  a_ovf_ien_keep: assert property (
    cen && clr_wr && !pwdata[rev_pkg::IRQ_OVF_BIT] && ien_r[rev_pkg::IRQ_OVF_BIT]
    |=> ien_r[rev_pkg::IRQ_OVF_BIT])
    else $error("zero write disturbed overflow enable");
  a_compare0_irq_en_ien_keep: assert property (
    cen && clr_wr && !pwdata[rev_pkg::IRQ_CH0_BIT] && ien_r[rev_pkg::IRQ_CH0_BIT]
    |=> ien_r[rev_pkg::IRQ_CH0_BIT])
    else $error("zero write disturbed compare 0 enable");
  a_event_output_control_unused: assert property (
    (event_output_control_r & ~rev_pkg::EV_WMASK) == 16'h0000)
    else $error("unused event control bit set");
  // set wins even against a same-cycle write-one clear
  a_flag_set_wins: assert property (
    cen && hits.ovf |=> flag_r[rev_pkg::IRQ_OVF_BIT])
    else $error("overflow flag not set by its condition");
  // a frozen block must neither pulse nor move
  a_freeze_quiet: assert property (
    !cen |-> evts == '0 && !pready)
    else $error("event or ready while clock enable low");
  a_freeze_state: assert property (
    !cen |=> $stable(event_output_control_r) && $stable(ien_r) && $stable(flag_r))
    else $error("state moved while clock enable low");
  // ready must never answer a request outside its access phase
  a_ready_access: assert property (
    pready |-> psel && penable)
    else $error("ready outside an access phase");

  c_ovf_event: cover property (cen && evts.ovf);
  c_ien_clear: cover property (cen && clr_wr ##1 irq == 1'b0);
  c_irq_fire:  cover property (!irq ##1 irq);
  c_cal_alarm: cover property (evts.alarm0);
  c_rsvd_mode: cover property (cen && mode_r == rev_pkg::REV_MODE_RSVD && evts.ovf);
endmodule

// >>> tb/rev_hit_src.sv
// Purpose: counter core stand-in that fires condition strobes
// Assumes: one strobe cycle per drive call pair
// Notes:   strobes idle at zero, as a real core leaves them
`timescale 1ns/100ps
module rev_hit_src (
  input  wire logic         pclk,
  output rev_pkg::rev_hit_t hits
);
  rev_pkg::rev_hit_t hits_r = '0;
  assign hits = hits_r;
  // changes only right after a rising edge
  task automatic drive(input rev_pkg::rev_hit_t v);
    @(posedge pclk);
    hits_r <= v;
  endtask
endmodule

// >>> tb/tb_rev_ctrl.sv
// Purpose: self-checking bench for rev_ctrl
// Assumes: cen high except in the freeze scenario; hits come from the core stand-in
// Notes:   byte address is register index times four
`timescale 1ns/100ps
module tb_rev_ctrl;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              cen = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  rev_pkg::rev_hit_t hits;
  rev_pkg::rev_evt_t evts;
  int                n_errors = 0;
  int                samples_checked = 0;
  rev_ctrl i_rev_ctrl (.pclk(pclk), .presetn(presetn), .cen(cen), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hits(hits),
    .evts(evts), .irq(irq));
  rev_hit_src i_rev_hit_src (.pclk(pclk), .hits(hits));
  initial
  begin
    forever #50 pclk = ~pclk;
  end
  task automatic wrap_up();
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait count assumed; the watchdog ends a hang
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, idx, d, q, e);
  endtask
  task automatic rd(input string nm, input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, idx, 32'h0, q, e);
    chk(nm, q, exp);
  endtask
  task automatic strobe(input rev_pkg::rev_hit_t v, input rev_pkg::rev_evt_t x);
    i_rev_hit_src.drive(v);
    #10;
    chk("evts", {20'h0, evts}, {20'h0, x});
    i_rev_hit_src.drive('0);
    #10;
    chk("evts_idle", {20'h0, evts}, 32'h0);
  endtask
  task automatic t_reset();
    rd("event_output_control", rev_pkg::IDX_EVENT_OUTPUT_CONTROL, 32'h0);
    rd("ienclr", rev_pkg::IDX_IENCLR, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask
  task automatic t_events();
    logic [15:0]       ev;
    rev_pkg::rev_evt_t x;
    for (int m = 0; m < 3; m++)
    begin
      for (int k = 0; k < 2; k++)
      begin
        // bit 8 alone, then bit 9 alone, to tell the channels apart
        ev = k ? 16'h025a : 16'h81a5;
        wr(rev_pkg::IDX_CTRL, 32'(m << 2));
        wr(rev_pkg::IDX_EVENT_OUTPUT_CONTROL, {16'h0, ev});
        x.ovf    = ev[15];
        x.cmp[0] = ev[8] & (m < 2);
        x.cmp[1] = ev[9] & (m == 1);
        x.alarm0 = ev[8] & (m == 2);
        x.per    = ev[7:0];
        strobe('1, x);
        chk("irq_off", {31'h0, irq}, 32'h0);
        wr(rev_pkg::IDX_FLAG, 32'hff);
      end
    end
  endtask
  task automatic t_protect();
    wr(rev_pkg::IDX_EVENT_OUTPUT_CONTROL, 32'h1);
    wr(rev_pkg::IDX_CTRL, 32'h2);
    wr(rev_pkg::IDX_EVENT_OUTPUT_CONTROL, 32'h8000);
    rd("ev_en", rev_pkg::IDX_EVENT_OUTPUT_CONTROL, 32'h1);
    wr(rev_pkg::IDX_CTRL, 32'h0);
    wr(rev_pkg::IDX_WPROT, 32'h1);
    wr(rev_pkg::IDX_EVENT_OUTPUT_CONTROL, 32'h8000);
    rd("ev_wp", rev_pkg::IDX_EVENT_OUTPUT_CONTROL, 32'h1);
    wr(rev_pkg::IDX_WPROT, 32'h0);
    wr(rev_pkg::IDX_EVENT_OUTPUT_CONTROL, 32'hffff);
    rd("ev_ok", rev_pkg::IDX_EVENT_OUTPUT_CONTROL, 32'h83ff);
  endtask
  task automatic t_irq();
    wr(rev_pkg::IDX_IENSET, 32'hc1);
    rd("ien", rev_pkg::IDX_IENCLR, 32'hc1);
    wr(rev_pkg::IDX_IENCLR, 32'h0);
    rd("ien0", rev_pkg::IDX_IENCLR, 32'hc1);
    wr(rev_pkg::IDX_IENCLR, 32'h80);
    rd("ien7", rev_pkg::IDX_IENCLR, 32'h41);
    wr(rev_pkg::IDX_IENCLR, 32'h40);
    rd("ien6", rev_pkg::IDX_IENCLR, 32'h01);
    wr(rev_pkg::IDX_IENCLR, 32'h01);
    rd("ien1", rev_pkg::IDX_IENCLR, 32'h00);
    wr(rev_pkg::IDX_IENSET, 32'h80);
    strobe(rev_pkg::rev_hit_t'(13'h1000), rev_pkg::rev_evt_t'(12'h800));
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(rev_pkg::IDX_IENCLR, 32'h80);
    // enable drops at the completing edge; look once it has settled
    #10;
    chk("irq_clr", {31'h0, irq}, 32'h0);
    wr(rev_pkg::IDX_FLAG, 32'hff);
  endtask
  task automatic t_corner();
    // reserved mode keeps only the mode-free events
    wr(rev_pkg::IDX_CTRL, 32'hc);
    strobe('1, rev_pkg::rev_evt_t'(12'h8ff));
    wr(rev_pkg::IDX_FLAG, 32'hff);
    wr(rev_pkg::IDX_CTRL, 32'h0);
    // clock enable low: no event, no flag
    @(posedge pclk);
    cen <= 1'b0;
    strobe('1, '0);
    @(posedge pclk);
    cen <= 1'b1;
    rd("flag_frz", rev_pkg::IDX_FLAG, 32'h0);
  endtask
  task automatic t_unmapped();
    logic [31:0] q;
    logic        e;
    apb(1'b0, 6'h0f, 32'h0, q, e);
    chk("slverr", {31'h0, e}, 32'h1);
    apb(1'b0, rev_pkg::IDX_EVENT_OUTPUT_CONTROL, 32'h0, q, e);
    chk("okay", {31'h0, e}, 32'h0);
  endtask
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_events();
    t_protect();
    t_irq();
    t_corner();
    t_unmapped();
    wrap_up();
  end
  initial
  begin
    #300000;
    n_errors++;
    wrap_up();
  end
endmodule
